// ===== hw/acir_pkg.sv
// Behaviour
// RULE1 - Done flag sets on every conversion end
// RULE2 - Only software clears the done flag
// RULE3 - Flag and enable sit in peripheral registers
// RULE4 - Conversion interrupt works awake and wakes sleep
// RULE5 - Sleep conversion only with dedicated RC clock
// RULE6 - Wake resumes at instruction after sleep
// RULE7 - Both enables set on wake vector to handler
// RULE8 - Format bit selects left or right justification
// RULE9 - Full acquisition before conversion after channel change
// RULE10 - Fixed bit placement for both formats, zeros elsewhere
// RULE11 - Request is flag AND enable, vectoring gated
package acir_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CONV_CONTROL_1_OFS     = 8'h00;
   localparam logic [7:0] IRQ_CONTROL_OFS        = 8'h04;
   localparam logic [7:0] PERIPH_IRQ_FLAGS_1_OFS = 8'h08;
   localparam logic [7:0] PERIPH_IRQ_ENABLES_1_OFS = 8'h0C;
   localparam logic [7:0] FLAG_CLEAR_OFS         = 8'h10;
   localparam logic [7:0] RESULT_HIGH_OFS        = 8'h14;
   localparam logic [7:0] RESULT_LOW_OFS         = 8'h18;
   localparam logic [7:0] CONV_STATUS_OFS        = 8'h1C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int GO_BIT            = 0;
   localparam int RC_SELECT_BIT     = 1;
   localparam int CHANNEL_LSB       = 2;
   localparam int CHANNEL_W         = 3;
   localparam int FORMAT_BIT        = 7;
   localparam int GLOBAL_EN_BIT     = 7;
   localparam int PERIPH_EN_BIT     = 6;
   localparam int CONV_DONE_BIT     = 6;
   localparam int STAT_BUSY_BIT     = 0;
   localparam int STAT_ACQ_BIT      = 1;
   localparam int STAT_ASLEEP_BIT   = 2;
   localparam int RESULT_W          = 10;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] CONV_CONTROL_1_RST = 8'h00;
   localparam logic [7:0] IRQ_CONTROL_RST    = 8'h00;
   localparam logic [7:0] ENABLES_1_RST      = 8'h00;
   localparam logic [9:0] RESULT_RST         = 10'h000;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS  = 25000;
   localparam int ACQ_TIME_PS    = 4970000;
   localparam int ACQ_CYCLES     = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYS_DIV_CYCLES = 32;
   localparam int CONV_TICKS     = 11;
   localparam logic [7:0] ACQ_LAST  = 8'(ACQ_CYCLES - 1);
   localparam logic [4:0] DIV_LAST  = 5'(SYS_DIV_CYCLES - 1);
   localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ACIR_IDLE = 2'b00,
      ACIR_CONV = 2'b01,
      ACIR_DONE = 2'b11
   } acir_state_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } acir_aphase_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } acir_result_t;

endpackage : acir_pkg

// ===== hw/acir_top.sv
`timescale 1ns/1ps
module acir_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sleep_in,
   input  wire logic        rc_clock_tick,
   input  wire logic [9:0]  sample_in,
   output logic             irq_req,
   output logic             irq_vector,
   output logic             wake_pulse,
   output logic             resume_next,
   output logic             hold_capacitor,
   output logic             irq_out
);

   // ****************************************
   // Declarations
   // ****************************************
   acir_pkg::acir_aphase_t aph_reg;
   acir_pkg::acir_state_t  state_reg;
   acir_pkg::acir_result_t result_fmt;
   logic [7:0]  conv_control_1_reg;
   logic [7:0]  irq_control_reg;
   logic [7:0]  periph_irq_enables_1_reg;
   logic        conv_done_flag_reg;
   logic [9:0]  result_reg;
   logic [7:0]  acq_cnt_reg;
   logic        acq_done_reg;
   logic [4:0]  div_cnt_reg;
   logic        sys_tick_reg;
   logic [3:0]  conv_cnt_reg;
   logic        rc_meta_reg;
   logic        rc_sync_reg;
   logic        rc_prev_reg;
   logic [9:0]  sample_meta_reg;
   logic [9:0]  sample_sync_reg;
   logic        asleep_reg;
   logic        wr_en;
   logic        rd_take;
   logic        conv_tick;
   logic        conv_end;
   logic        start_go;
   logic        chan_change;
   logic        clear_done;
   logic        flag_and_en;
   logic [31:0] rd_data;
   logic [7:0]  wbyte;

   // ****************************************
   // Bus slave
   // ****************************************
   assign rd_take = hsel & hready & htrans[1];
   assign wr_en   = aph_reg.valid & aph_reg.write;
   assign wbyte   = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_reg <= '0;
      end else if (hready) begin
         aph_reg.valid <= rd_take;
         aph_reg.write <= hwrite;
         aph_reg.addr  <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (haddr[7:0])
         acir_pkg::CONV_CONTROL_1_OFS: begin
            rd_data[7:0] = conv_control_1_reg;
         end
         acir_pkg::IRQ_CONTROL_OFS: begin
            rd_data[7:0] = irq_control_reg;
         end
         acir_pkg::PERIPH_IRQ_FLAGS_1_OFS: begin
            rd_data[acir_pkg::CONV_DONE_BIT] = conv_done_flag_reg; // RULE3
         end
         acir_pkg::PERIPH_IRQ_ENABLES_1_OFS: begin
            rd_data[7:0] = periph_irq_enables_1_reg;
         end
         acir_pkg::RESULT_HIGH_OFS: begin
            rd_data[7:0] = result_fmt.high;
         end
         acir_pkg::RESULT_LOW_OFS: begin
            rd_data[7:0] = result_fmt.low;
         end
         acir_pkg::CONV_STATUS_OFS: begin
            rd_data[acir_pkg::STAT_BUSY_BIT]   = (state_reg == acir_pkg::ACIR_CONV);
            rd_data[acir_pkg::STAT_ACQ_BIT]    = acq_done_reg;
            rd_data[acir_pkg::STAT_ASLEEP_BIT] = asleep_reg;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in address phase, shown in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take && !hwrite) begin
         hrdata <= rd_data;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   assign start_go    = wr_en && aph_reg.addr == acir_pkg::CONV_CONTROL_1_OFS && wbyte[acir_pkg::GO_BIT];
   assign chan_change = wr_en && aph_reg.addr == acir_pkg::CONV_CONTROL_1_OFS
                        && wbyte[acir_pkg::CHANNEL_LSB +: acir_pkg::CHANNEL_W]
                           != conv_control_1_reg[acir_pkg::CHANNEL_LSB +: acir_pkg::CHANNEL_W];
   assign clear_done  = wr_en && aph_reg.addr == acir_pkg::FLAG_CLEAR_OFS && wbyte[acir_pkg::CONV_DONE_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_control_1_reg <= acir_pkg::CONV_CONTROL_1_RST;
      end else if (wr_en && aph_reg.addr == acir_pkg::CONV_CONTROL_1_OFS) begin
         conv_control_1_reg <= {wbyte[7:1], conv_control_1_reg[acir_pkg::GO_BIT] | start_go};
      end else if (conv_end || (state_reg == acir_pkg::ACIR_IDLE && conv_control_1_reg[acir_pkg::GO_BIT]
                                && !start_ok())) begin
         conv_control_1_reg[acir_pkg::GO_BIT] <= conv_end ? 1'b0 : conv_control_1_reg[acir_pkg::GO_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_control_reg <= acir_pkg::IRQ_CONTROL_RST;
      end else if (wr_en && aph_reg.addr == acir_pkg::IRQ_CONTROL_OFS) begin
         irq_control_reg <= wbyte & 8'hC0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_irq_enables_1_reg <= acir_pkg::ENABLES_1_RST;
      end else if (wr_en && aph_reg.addr == acir_pkg::PERIPH_IRQ_ENABLES_1_OFS) begin
         periph_irq_enables_1_reg <= wbyte & 8'h40; // RULE3
      end
   end

   // ****************************************
   // Acquisition timer
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acq_cnt_reg  <= 8'h00;
         acq_done_reg <= 1'b0;
      end else if (chan_change || conv_end) begin
         acq_cnt_reg  <= 8'h00;
         acq_done_reg <= 1'b0;
      end else if (!acq_done_reg) begin
         acq_cnt_reg  <= acq_cnt_reg + 8'h01;
         acq_done_reg <= (acq_cnt_reg == acir_pkg::ACQ_LAST); // RULE9
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_capacitor <= 1'b1;
      end else begin
         hold_capacitor <= (state_reg != acir_pkg::ACIR_CONV);
      end
   end

   // ****************************************
   // Conversion clock sources
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rc_meta_reg     <= 1'b0;
         rc_sync_reg     <= 1'b0;
         rc_prev_reg     <= 1'b0;
         sample_meta_reg <= 10'h000;
         sample_sync_reg <= 10'h000;
      end else begin
         rc_meta_reg     <= rc_clock_tick;
         rc_sync_reg     <= rc_meta_reg;
         rc_prev_reg     <= rc_sync_reg;
         sample_meta_reg <= sample_in;
         sample_sync_reg <= sample_meta_reg;
      end
   end

   // System divider halts while asleep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg  <= 5'h00;
         sys_tick_reg <= 1'b0;
      end else if (asleep_reg) begin
         div_cnt_reg  <= 5'h00;
         sys_tick_reg <= 1'b0;
      end else begin
         div_cnt_reg  <= (div_cnt_reg == acir_pkg::DIV_LAST) ? 5'h00 : div_cnt_reg + 5'h01;
         sys_tick_reg <= (div_cnt_reg == acir_pkg::DIV_LAST);
      end
   end

   assign conv_tick = conv_control_1_reg[acir_pkg::RC_SELECT_BIT] ? (rc_sync_reg & ~rc_prev_reg)
                                                                  : sys_tick_reg; // RULE5

   function automatic logic start_ok();
      start_ok = acq_done_reg && (!asleep_reg || conv_control_1_reg[acir_pkg::RC_SELECT_BIT]); // RULE5
   endfunction : start_ok

   // ****************************************
   // Conversion sequencer
   // ****************************************
   assign conv_end = (state_reg == acir_pkg::ACIR_CONV) && conv_tick && (conv_cnt_reg == acir_pkg::CONV_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= acir_pkg::ACIR_IDLE;
         conv_cnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            acir_pkg::ACIR_IDLE: begin
               conv_cnt_reg <= 4'h0;
               if (conv_control_1_reg[acir_pkg::GO_BIT] && start_ok()) begin
                  state_reg <= acir_pkg::ACIR_CONV;
               end
            end
            acir_pkg::ACIR_CONV: begin
               if (asleep_reg && !conv_control_1_reg[acir_pkg::RC_SELECT_BIT]) begin
                  state_reg <= acir_pkg::ACIR_IDLE; // RULE5
               end else if (conv_end) begin
                  state_reg <= acir_pkg::ACIR_DONE;
               end else if (conv_tick) begin
                  conv_cnt_reg <= conv_cnt_reg + 4'h1;
               end
            end
            acir_pkg::ACIR_DONE: begin
               state_reg <= acir_pkg::ACIR_IDLE;
            end
            default: begin
               state_reg <= acir_pkg::ACIR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_reg <= acir_pkg::RESULT_RST;
      end else if (conv_end) begin
         result_reg <= sample_sync_reg;
      end
   end

   always_comb begin
      if (conv_control_1_reg[acir_pkg::FORMAT_BIT]) begin // RULE8
         result_fmt.high = {6'h00, result_reg[9:8]}; // RULE10
         result_fmt.low  = result_reg[7:0];
      end else begin
         result_fmt.high = result_reg[9:2]; // RULE10
         result_fmt.low  = {result_reg[1:0], 6'h00};
      end
   end

   // ****************************************
   // Completion flag and interrupt
   // ****************************************
   // Set wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_done_flag_reg <= 1'b0;
      end else if (conv_end) begin
         conv_done_flag_reg <= 1'b1; // RULE1
      end else if (clear_done) begin
         conv_done_flag_reg <= 1'b0; // RULE2
      end
   end

   assign flag_and_en = conv_done_flag_reg & periph_irq_enables_1_reg[acir_pkg::CONV_DONE_BIT]; // RULE11

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req    <= 1'b0;
         irq_vector <= 1'b0;
         irq_out    <= 1'b0;
      end else begin
         irq_req    <= flag_and_en; // RULE3
         irq_out    <= flag_and_en; // RULE4
         irq_vector <= flag_and_en & irq_control_reg[acir_pkg::GLOBAL_EN_BIT]
                       & irq_control_reg[acir_pkg::PERIPH_EN_BIT]; // RULE7 RULE11
      end
   end

   // ****************************************
   // Sleep and wake
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         asleep_reg  <= 1'b0;
         wake_pulse  <= 1'b0;
         resume_next <= 1'b0;
      end else begin
         wake_pulse  <= 1'b0;
         resume_next <= 1'b0;
         if (asleep_reg && flag_and_en) begin
            asleep_reg  <= 1'b0;
            wake_pulse  <= 1'b1; // RULE4
            resume_next <= 1'b1; // RULE6
         end else if (sleep_in && !asleep_reg && !wake_pulse) begin
            asleep_reg <= 1'b1;
         end
      end
   end

   // Vectoring after the post-sleep instruction follows irq_vector
   // RULE7

endmodule : acir_top

// ===== bench/acir_top_sva.sv
`timescale 1ns/1ps
module acir_chk (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       sleep_in,
   input wire logic       irq_req,
   input wire logic       irq_vector,
   input wire logic       wake_pulse,
   input wire logic       resume_next,
   input wire logic       hold_capacitor,
   input wire logic       irq_out
);
   logic wr_ph;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Marks the data phase of a register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
      end else begin
         wr_ph <= hsel && hready && htrans[1] && hwrite;
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   a_irq_mirror: assert property (irq_out == irq_req)
      else $error("irq_out differs from irq_req");
   a_vector_gated: assert property (irq_vector |-> irq_req)
      else $error("irq_vector without irq_req");
   a_wake_resume: assert property (wake_pulse |-> resume_next)
      else $error("wake without resume");
   a_resume_wake: assert property (resume_next |-> wake_pulse)
      else $error("resume without wake");
   a_wake_once: assert property (wake_pulse |=> !wake_pulse)
      else $error("wake pulse longer than one cycle");
   a_wake_asleep: assert property (wake_pulse |-> $past(sleep_in))
      else $error("wake while not asleep");
   a_wake_cause: assert property (wake_pulse |-> ##[0:2] irq_out)
      else $error("wake without interrupt");
   a_req_sticky: assert property ($fell(irq_req) |-> $past(wr_ph) || $past(wr_ph, 2))
      else $error("irq_req dropped without a write");
   a_req_source: assert property ($rose(irq_req) |-> $past(!hold_capacitor) || $past(wr_ph) || $past(wr_ph, 2))
      else $error("irq_req rose without conversion end");

   c_wake: cover property (wake_pulse && irq_vector);
   c_clear: cover property ($fell(irq_req));
   c_inline: cover property (irq_req && !irq_vector);
endmodule : acir_chk

bind acir_top acir_chk u_acir_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .sleep_in(sleep_in), .irq_req(irq_req), .irq_vector(irq_vector),
   .wake_pulse(wake_pulse), .resume_next(resume_next), .hold_capacitor(hold_capacitor), .irq_out(irq_out));

// ===== bench/acir_core_model.sv
`timescale 1ns/1ps
module acir_core_model #(
   parameter int FAST_HALF = 3,
   parameter int SLOW_HALF = 9
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic rc_run,
   input  wire logic rc_slow,
   input  wire logic sleep_go,
   input  wire logic wake_pulse,
   output logic      sleep_in,
   output logic      rc_clock_tick
);
   int half_cnt;

   // Dedicated RC clock, still while not running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_cnt      <= 0;
         rc_clock_tick <= 1'b0;
      end else if (!rc_run) begin
         half_cnt      <= 0;
         rc_clock_tick <= 1'b0;
      end else if (half_cnt >= (rc_slow ? SLOW_HALF : FAST_HALF) - 1) begin
         half_cnt      <= 0;
         rc_clock_tick <= ~rc_clock_tick;
      end else begin
         half_cnt <= half_cnt + 1;
      end
   end

   // Core sleeps on request, resumes only on wake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_in <= 1'b0;
      end else if (wake_pulse) begin
         sleep_in <= 1'b0;
      end else if (sleep_go) begin
         sleep_in <= 1'b1;
      end
   end
endmodule : acir_core_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] GO   = 8'(1 << acir_pkg::GO_BIT);
   localparam logic [7:0] RC   = 8'(1 << acir_pkg::RC_SELECT_BIT);
   localparam logic [7:0] CH1  = 8'(1 << acir_pkg::CHANNEL_LSB);
   localparam logic [7:0] FMT  = 8'(1 << acir_pkg::FORMAT_BIT);
   localparam logic [7:0] DONE = 8'(1 << acir_pkg::CONV_DONE_BIT);
   localparam logic [7:0] BOTH = 8'((1 << acir_pkg::GLOBAL_EN_BIT) | (1 << acir_pkg::PERIPH_EN_BIT));
   localparam int         ACQ  = acir_pkg::ACQ_CYCLES + 4;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_in, rc_clock_tick;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [9:0]  sample_in;
   logic        irq_req, irq_vector, wake_pulse, resume_next, hold_capacitor, irq_out;
   logic        rc_run, rc_slow, sleep_go;
   int          bad_count;
   int          comparisons;

   always #12.5 hclk = ~hclk;

   acir_top u_acir_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sleep_in(sleep_in), .rc_clock_tick(rc_clock_tick),
      .sample_in(sample_in), .irq_req(irq_req), .irq_vector(irq_vector), .wake_pulse(wake_pulse),
      .resume_next(resume_next), .hold_capacitor(hold_capacitor), .irq_out(irq_out));
   acir_core_model u_acir_core_model (.hclk(hclk), .hresetn(hresetn), .rc_run(rc_run), .rc_slow(rc_slow),
      .sleep_go(sleep_go), .wake_pulse(wake_pulse), .sleep_in(sleep_in), .rc_clock_tick(rc_clock_tick));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      q = hrdata;
   endtask : bus

   task automatic poll_flag();
      int n;
      n = 0;
      do begin
         bus(1'b0, acir_pkg::PERIPH_IRQ_FLAGS_1_OFS, 8'h00);
         n++;
      end while (q[acir_pkg::CONV_DONE_BIT] !== 1'b1 && n < 400);
   endtask : poll_flag

   task automatic convert(input logic [9:0] s, input logic [7:0] ctl);
      sample_in <= s;
      bus(1'b1, acir_pkg::CONV_CONTROL_1_OFS, ctl);
      repeat (ACQ) @(posedge hclk);
      bus(1'b1, acir_pkg::CONV_CONTROL_1_OFS, ctl | GO);
   endtask : convert

   task automatic result(input logic [7:0] hi, input logic [7:0] lo);
      bus(1'b0, acir_pkg::RESULT_HIGH_OFS, 8'h00);
      chk("result high", {24'h000000, hi}, q);
      bus(1'b0, acir_pkg::RESULT_LOW_OFS, 8'h00);
      chk("result low", {24'h000000, lo}, q);
   endtask : result

   task automatic close_out();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      bus(1'b1, 8'h24, 8'hFF);
      for (int i = 0; i < 10; i++) begin
         if (i != 4) begin
            bus(1'b0, 8'(i * 4), 8'h00);
            chk("reset or unmapped read", 32'h0, q);
         end
      end
      chk("hresp okay", 32'h0, {31'h0, hresp});
      chk("hold while idle", 32'h1, {31'h0, hold_capacitor});
   endtask : t_reset

   task automatic t_left();
      convert(10'h2D7, CH1);
      poll_flag();
      chk("done flag", {24'h000000, DONE}, q);
      chk("irq_out masked", 32'h0, {31'h0, irq_out});
      result(8'hB5, 8'hC0);
      repeat (50) @(posedge hclk);
      bus(1'b0, acir_pkg::PERIPH_IRQ_FLAGS_1_OFS, 8'h00);
      chk("flag sticky", {24'h000000, DONE}, q);
      bus(1'b1, acir_pkg::FLAG_CLEAR_OFS, DONE);
      bus(1'b0, acir_pkg::PERIPH_IRQ_FLAGS_1_OFS, 8'h00);
      chk("flag cleared", 32'h0, q);
   endtask : t_left

   task automatic t_right();
      bus(1'b1, acir_pkg::PERIPH_IRQ_ENABLES_1_OFS, DONE);
      convert(10'h1A5, CH1 | FMT);
      poll_flag();
      repeat (2) @(posedge hclk);
      chk("irq_out enabled", 32'h1, {31'h0, irq_out});
      chk("irq_req enabled", 32'h1, {31'h0, irq_req});
      chk("no vector", 32'h0, {31'h0, irq_vector});
      result(8'h01, 8'hA5);
      bus(1'b1, acir_pkg::FLAG_CLEAR_OFS, DONE);
      repeat (2) @(posedge hclk);
      chk("irq_out after clear", 32'h0, {31'h0, irq_out});
   endtask : t_right

   task automatic t_sleep_rc();
      int n;
      n = 0;
      bus(1'b1, acir_pkg::IRQ_CONTROL_OFS, BOTH);
      rc_slow <= 1'b1;
      rc_run  <= 1'b1;
      convert(10'h3FF, CH1 | RC);
      sleep_go <= 1'b1;
      @(posedge hclk);
      sleep_go <= 1'b0;
      while (wake_pulse !== 1'b1 && n < 3000) begin
         @(negedge hclk);
         n++;
      end
      chk("wake", 32'h1, {31'h0, wake_pulse});
      chk("resume next", 32'h1, {31'h0, resume_next});
      chk("vector", 32'h1, {31'h0, irq_vector});
      repeat (2) @(posedge hclk);
      chk("awake", 32'h0, {31'h0, sleep_in});
      result(8'hFF, 8'hC0);
      bus(1'b1, acir_pkg::FLAG_CLEAR_OFS, DONE);
      bus(1'b1, acir_pkg::IRQ_CONTROL_OFS, 8'h00);
   endtask : t_sleep_rc

   task automatic t_sleep_norc();
      rc_slow <= 1'b0;
      convert(10'h155, CH1);
      sleep_go <= 1'b1;
      @(posedge hclk);
      sleep_go <= 1'b0;
      repeat (800) @(posedge hclk);
      bus(1'b0, acir_pkg::PERIPH_IRQ_FLAGS_1_OFS, 8'h00);
      chk("no sleep conversion", 32'h0, q);
      bus(1'b0, acir_pkg::CONV_STATUS_OFS, 8'h00);
      chk("asleep", 32'h1, {31'h0, q[acir_pkg::STAT_ASLEEP_BIT]});
      chk("aborted not busy", 32'h0, {31'h0, q[acir_pkg::STAT_BUSY_BIT]});
   endtask : t_sleep_norc

   initial begin
      hclk      = 1'b0;
      hresetn   = 1'b0;
      hsel      = 1'b1;
      haddr     = 32'h00000000;
      htrans    = 2'h0;
      hwrite    = 1'b0;
      hsize     = 3'h2;
      hwdata    = 32'h00000000;
      sample_in = 10'h000;
      rc_run    = 1'b0;
      rc_slow   = 1'b0;
      sleep_go  = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_left();
      t_right();
      t_sleep_rc();
      t_sleep_norc();
      close_out();
   end

   initial begin
      #(20000 * 25);
      bad_count++;
      close_out();
   end
endmodule : tb
